// ===== clock_input_path_and_system_ctrl.sv
/*
  Control logic for the clock input path, prescaling divider and system controls.
  Assumes the host keeps the serial port rules and the channel dividers are elsewhere.
*/
`timescale 1ns/10ps
`default_nettype none

module clock_input_path_and_system_ctrl #(
  parameter int N_CHAN = 3
) (
  input  wire logic                             sys_clk,
  input  wire logic                             sys_rst,
  input  wire logic                             sclk_pin,
  input  wire logic                             cs_n_pin,
  input  wire logic                             sdio_pin,
  input  wire logic                             sync_n_pin,
  input  wire logic [N_CHAN-1:0]                chan_ignore_sync,
  input  wire logic [N_CHAN-1:0]                chan_direct,
  output logic                                  sdo,
  output logic                                  sdo_oe,
  output logic [3:0]                            prescale_ratio,
  output logic                                  prescale_static,
  output logic                                  prescale_bypass,
  output logic                                  src_internal,
  output logic                                  pd_input_section,
  output logic                                  pd_osc_interface,
  output logic                                  pd_sources,
  output logic                                  pd_sync,
  output logic                                  pd_dist_ref,
  output logic [N_CHAN-1:0]                     chan_hold,
  output logic [N_CHAN-1:0]                     chan_sync_pulse,
  output clk_path_pkg::chan_src_t [N_CHAN-1:0]  chan_src
);

  // ==========================================================================
  // Serial port.
  clk_path_pkg::ser_access_t acc;
  logic [12:0]               rd_addr;
  logic                      sclk_rise;
  logic [7:0]                rd_data;

  serial_ctrl_port u_port (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .sclk_pin  (sclk_pin),
    .cs_n_pin  (cs_n_pin),
    .sdio_pin  (sdio_pin),
    .rd_data   (rd_data),
    .access    (acc),
    .rd_addr   (rd_addr),
    .sclk_rise (sclk_rise),
    .sdo       (sdo),
    .sdo_oe    (sdo_oe)
  );

  // ==========================================================================
  // Buffer registers.
  logic [2:0] pre_buf_ff;
  logic [4:0] path_buf_ff;
  logic [2:0] sys_buf_ff;
  logic       apply_ff;
  logic       nxt_apply;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pre_buf_ff  <= clk_path_pkg::PRE_CODE_RST;
      path_buf_ff <= clk_path_pkg::PATH_RST;
      sys_buf_ff  <= clk_path_pkg::SYS_RST_VAL;
    end else if (acc.wr) begin
      unique case (acc.addr)
        clk_path_pkg::ADDR_PRESCALE:   pre_buf_ff  <= acc.data[2:0];
        clk_path_pkg::ADDR_INPUT_PATH: path_buf_ff <= acc.data[4:0];
        clk_path_pkg::ADDR_SYSTEM:     sys_buf_ff  <= acc.data[2:0];
        default: begin
        end
      endcase
    end
  end

  // Self clearing update.
  // A write that arms the bit wins over the transfer that clears it.
  always_comb begin
    nxt_apply = apply_ff & ~sclk_rise;
    if (acc.wr && acc.addr == clk_path_pkg::ADDR_APPLY && acc.data[clk_path_pkg::BIT_APPLY]) begin
      nxt_apply = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      apply_ff <= 1'b0;
    end else begin
      apply_ff <= nxt_apply;
    end
  end

  always_comb begin
    rd_data = 8'h00;
    unique case (rd_addr)
      clk_path_pkg::ADDR_PRESCALE:   rd_data[2:0] = pre_buf_ff;
      clk_path_pkg::ADDR_INPUT_PATH: rd_data[4:0] = path_buf_ff;
      clk_path_pkg::ADDR_SYSTEM:     rd_data[2:0] = sys_buf_ff;
      clk_path_pkg::ADDR_APPLY:      rd_data[0]   = apply_ff;
      default:                       rd_data      = 8'h00;
    endcase
  end

  // ==========================================================================
  // Active registers.
  logic [2:0] pre_act_ff;
  logic [4:0] path_act_ff;
  logic [2:0] sys_act_ff;
  logic       do_apply;

  assign do_apply = apply_ff & sclk_rise;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pre_act_ff  <= clk_path_pkg::PRE_CODE_RST;
      path_act_ff <= clk_path_pkg::PATH_RST;
      sys_act_ff  <= clk_path_pkg::SYS_RST_VAL;
    end else if (do_apply) begin
      pre_act_ff  <= pre_buf_ff;
      path_act_ff <= path_buf_ff;
      sys_act_ff  <= sys_buf_ff;
    end
  end

  // ==========================================================================
  // Clock path controls.
  function automatic logic [3:0] ratio_of(input logic [2:0] code);
    logic [3:0] r;
    r = 4'h0;
    if (code <= clk_path_pkg::PRE_CODE_MAX) begin
      r = clk_path_pkg::PRE_RATIO_BASE + {1'b0, code};
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prescale_ratio   <= ratio_of(clk_path_pkg::PRE_CODE_RST);
      prescale_static  <= 1'b0;
      prescale_bypass  <= 1'b0;
      src_internal     <= 1'b0;
      pd_input_section <= 1'b0;
      pd_osc_interface <= 1'b0;
      pd_sources       <= 1'b0;
      pd_sync          <= 1'b0;
      pd_dist_ref      <= 1'b0;
    end else begin
      prescale_ratio   <= ratio_of(pre_act_ff);
      prescale_static  <= pre_act_ff > clk_path_pkg::PRE_CODE_MAX;
      // Oscillator cannot be bypassed, so the bypass is refused for it.
      prescale_bypass  <= path_act_ff[clk_path_pkg::BIT_BYPASS]
                          & ~path_act_ff[clk_path_pkg::BIT_SRC_OSC];
      src_internal     <= path_act_ff[clk_path_pkg::BIT_SRC_OSC];
      pd_input_section <= path_act_ff[clk_path_pkg::BIT_PD_INPUT];
      pd_osc_interface <= path_act_ff[clk_path_pkg::BIT_PD_OSC_IF];
      pd_sources       <= path_act_ff[clk_path_pkg::BIT_PD_SOURCES];
      pd_sync          <= sys_act_ff[clk_path_pkg::BIT_PD_SYNC];
      pd_dist_ref      <= sys_act_ff[clk_path_pkg::BIT_PD_DISTREF];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int c = 0; c < N_CHAN; c++) begin
        chan_src[c] <= clk_path_pkg::SRC_DIVIDER;
      end
    end else begin
      for (int c = 0; c < N_CHAN; c++) begin
        chan_src[c] <= clk_path_pkg::SRC_DIVIDER;
        if (chan_direct[c] && path_act_ff[1:0] == clk_path_pkg::SEL_OSC) begin
          chan_src[c] <= clk_path_pkg::SRC_OSC;
        end else if (chan_direct[c] && path_act_ff[1:0] == clk_path_pkg::SEL_EXT) begin
          chan_src[c] <= clk_path_pkg::SRC_EXT;
        end
      end
    end
  end

  // ==========================================================================
  // Synchronisation.
  // The pin passes three stages; a level counts once the last two agree.
  logic sy1_ff;
  logic sy2_ff;
  logic sy3_ff;
  logic pin_low_ff;
  logic sync_act_ff;
  logic sync_now;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sy1_ff     <= 1'b1;
      sy2_ff     <= 1'b1;
      sy3_ff     <= 1'b1;
      pin_low_ff <= 1'b0;
    end else begin
      sy1_ff <= sync_n_pin;
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      if (sy2_ff == sy3_ff) begin
        pin_low_ff <= ~sy3_ff;
      end
    end
  end

  assign sync_now = (pin_low_ff | sys_act_ff[clk_path_pkg::BIT_SOFT_SYNC])
                    & ~sys_act_ff[clk_path_pkg::BIT_PD_SYNC];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_act_ff     <= 1'b0;
      chan_hold       <= '0;
      chan_sync_pulse <= '0;
    end else begin
      sync_act_ff     <= sync_now;
      chan_hold       <= {N_CHAN{sync_now}} & ~chan_ignore_sync;
      // Powering the sync circuit down mid-hold must not release the channels with a pulse.
      chan_sync_pulse <= {N_CHAN{sync_act_ff & ~sync_now
                                 & ~sys_act_ff[clk_path_pkg::BIT_PD_SYNC]}} & ~chan_ignore_sync;
    end
  end

endmodule

`default_nettype wire

// ===== clk_path_pkg.sv
/*
  Shared constants and types for the clock input path and system control block.
  Assumes the serial control port carries a 16-bit instruction and one data byte.
*/
package clk_path_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [12:0] ADDR_PRESCALE   = 13'h01E0;
  localparam logic [12:0] ADDR_INPUT_PATH = 13'h01E1;
  localparam logic [12:0] ADDR_SYSTEM     = 13'h0230;
  localparam logic [12:0] ADDR_APPLY      = 13'h0232;

  // ==========================================================================
  // Field positions.
  localparam int PRE_CODE_W     = 3;
  localparam int PATH_W         = 5;
  localparam int SYS_W          = 3;
  localparam int BIT_PD_INPUT   = 4;
  localparam int BIT_PD_OSC_IF  = 3;
  localparam int BIT_PD_SOURCES = 2;
  localparam int BIT_SRC_OSC    = 1;
  localparam int BIT_BYPASS     = 0;
  localparam int BIT_PD_SYNC    = 2;
  localparam int BIT_PD_DISTREF = 1;
  localparam int BIT_SOFT_SYNC  = 0;
  localparam int BIT_APPLY      = 0;

  // ==========================================================================
  // Reset values and divider encoding.
  localparam logic [2:0] PRE_CODE_RST   = 3'h2;
  localparam logic [4:0] PATH_RST       = 5'h00;
  localparam logic [2:0] SYS_RST_VAL    = 3'h0;
  localparam logic [2:0] PRE_CODE_MAX   = 3'h4;
  localparam logic [3:0] PRE_RATIO_BASE = 4'h2;
  localparam logic [1:0] SEL_EXT        = 2'h0;
  localparam logic [1:0] SEL_OSC        = 2'h2;

  // ==========================================================================
  // Serial frame layout.
  localparam int          INSTR_BITS = 16;
  localparam int          ADDR_W     = 13;
  localparam int          CNT_W      = 5;
  localparam logic [4:0]  INSTR_LAST = 5'h0F;
  localparam logic [4:0]  FRAME_LAST = 5'h17;
  localparam logic [4:0]  FRAME_DONE = 5'h18;
  localparam int          RW_BIT     = 15;

  typedef enum logic [1:0] {
    SRC_DIVIDER,
    SRC_OSC,
    SRC_EXT
  } chan_src_t;

  typedef struct packed {
    logic        wr;
    logic [12:0] addr;
    logic [7:0]  data;
  } ser_access_t;

endpackage

// ===== serial_ctrl_port.sv
/*
  Serial control port slave: filters the pins, decodes frames and returns read data.
  Assumes the host drives clock, select and data pins asynchronously to sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module serial_ctrl_port (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  sclk_pin,
  input  wire logic                  cs_n_pin,
  input  wire logic                  sdio_pin,
  input  wire logic [7:0]            rd_data,
  output clk_path_pkg::ser_access_t  access,
  output logic [12:0]                rd_addr,
  output logic                       sclk_rise,
  output logic                       sdo,
  output logic                       sdo_oe
);

  // ==========================================================================
  // Pin filter.
  // A pin change is accepted only once the second and third stages agree.
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] s3_ff;
  logic [2:0] filt_ff;
  logic [2:0] nxt_filt;

  always_comb begin
    nxt_filt = filt_ff;
    for (int i = 0; i < 3; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_filt[i] = s2_ff[i];
      end
    end
  end

  // Reset to the idle pin levels, select high and clock low, so that no false select
  // or clock edge is seen just after reset.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1_ff   <= 3'h4;
      s2_ff   <= 3'h4;
      s3_ff   <= 3'h4;
      filt_ff <= 3'h4;
    end else begin
      s1_ff   <= {cs_n_pin, sclk_pin, sdio_pin};
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  logic rise;
  logic cs_act;
  assign rise   = nxt_filt[1] & ~filt_ff[1];
  assign cs_act = ~filt_ff[2];

  // ==========================================================================
  // Frame decode.
  logic [4:0]  cnt_ff;
  logic [15:0] sh_ff;
  logic [15:0] instr_ff;
  logic        rd_load_ff;
  logic [7:0]  rd_sh_ff;

  assign rd_addr = instr_ff[12:0];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_ff     <= '0;
      sh_ff      <= '0;
      instr_ff   <= '0;
      access     <= '0;
      sclk_rise  <= 1'b0;
      rd_load_ff <= 1'b0;
      rd_sh_ff   <= '0;
      sdo        <= 1'b0;
      sdo_oe     <= 1'b0;
    end else begin
      sclk_rise  <= rise;
      access.wr  <= 1'b0;
      rd_load_ff <= 1'b0;
      if (!cs_act) begin
        cnt_ff <= '0;
        sdo_oe <= 1'b0;
      end else if (rise && cnt_ff != clk_path_pkg::FRAME_DONE) begin
        sh_ff  <= {sh_ff[14:0], filt_ff[0]};
        cnt_ff <= cnt_ff + 5'h01;
        if (cnt_ff == clk_path_pkg::INSTR_LAST) begin
          instr_ff   <= {sh_ff[14:0], filt_ff[0]};
          rd_load_ff <= sh_ff[clk_path_pkg::RW_BIT - 1];
        end
        if (instr_ff[clk_path_pkg::RW_BIT] && cnt_ff > clk_path_pkg::INSTR_LAST) begin
          rd_sh_ff <= {rd_sh_ff[6:0], 1'b0};
          sdo      <= rd_sh_ff[6];
        end
        if (cnt_ff == clk_path_pkg::FRAME_LAST && !instr_ff[clk_path_pkg::RW_BIT]) begin
          access.wr   <= 1'b1;
          access.addr <= instr_ff[12:0];
          access.data <= {sh_ff[6:0], filt_ff[0]};
        end
      end
      if (rd_load_ff) begin
        rd_sh_ff <= rd_data;
        sdo      <= rd_data[7];
        sdo_oe   <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== clk_path_checker.sv
/* Checks the clock path outputs against their configuration.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module clk_path_checker #(
  parameter int N_CHAN = 3
) (
  input wire logic                                 sys_clk,
  input wire logic                                 sys_rst,
  input wire logic [N_CHAN-1:0]                    chan_ignore_sync,
  input wire logic [3:0]                           prescale_ratio,
  input wire logic                                 prescale_static,
  input wire logic                                 prescale_bypass,
  input wire logic                                 src_internal,
  input wire logic                                 pd_sync,
  input wire logic [N_CHAN-1:0]                    chan_hold,
  input wire logic [N_CHAN-1:0]                    chan_sync_pulse,
  input wire clk_path_pkg::chan_src_t [N_CHAN-1:0] chan_src
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Assertions.
  chk_static_ratio: assert property (prescale_static |-> prescale_ratio == 4'h0)
    else $error("static code with a ratio");
  chk_ratio_range: assert property (!prescale_static |->
    prescale_ratio inside {[4'h2:4'h6]})
    else $error("ratio out of range");
  chk_reset_state: assert property ($fell(sys_rst) |->
    prescale_ratio == 4'h4 && chan_hold == '0 && !pd_sync && !src_internal)
    else $error("wrong state after reset");
  chk_bypass_osc: assert property (src_internal |-> !prescale_bypass)
    else $error("oscillator routed around divider");
  chk_ignore_hold: assert property (
    (chan_hold & chan_ignore_sync & $past(chan_ignore_sync)) == '0)
    else $error("ignoring channel held");
  chk_pulse_width: assert property (|chan_sync_pulse |=>
    (chan_sync_pulse & $past(chan_sync_pulse)) == '0)
    else $error("sync pulse too long");
  chk_pulse_cause: assert property (|chan_sync_pulse |->
    (chan_sync_pulse & ~$past(chan_hold)) == '0)
    else $error("sync pulse without hold");
  chk_sync_off: assert property (pd_sync && $past(pd_sync, 3) |->
    chan_hold == '0 && chan_sync_pulse == '0)
    else $error("sync acts while powered down");
  for (genvar i = 0; i < N_CHAN; i++) begin : g_ch
    chk_direct_route: assert property (chan_src[i] != clk_path_pkg::SRC_DIVIDER |->
      !prescale_bypass && src_internal == (chan_src[i] == clk_path_pkg::SRC_OSC))
      else $error("direct route disagrees with source");
  end
  cover property (|chan_sync_pulse);
  cover property (prescale_static);
  cover property (chan_src[0] == clk_path_pkg::SRC_OSC);
endmodule
bind clock_input_path_and_system_ctrl clk_path_checker #(.N_CHAN(N_CHAN)) i_clk_path_checker (
  .sys_clk, .sys_rst, .chan_ignore_sync, .prescale_ratio, .prescale_static, .prescale_bypass,
  .src_internal, .pd_sync, .chan_hold, .chan_sync_pulse, .chan_src);
`default_nettype wire

// ===== serial_host_model.sv
/* Host on the serial control port: sends 24-bit frames, MSB first.
   Assumes sdo is sampled only in the data phase of a read. */
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  input  wire logic sys_clk,
  input  wire logic sdo,
  output var  logic sclk_pin,
  output var  logic cs_n_pin,
  output var  logic sdio_pin
);
  initial begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    sdio_pin = 1'b0;
  end
  // ==========================================================
  // Frame task. Half periods of 10 cycles leave margin over the filter.
  task automatic xfer(input logic [23:0] frm, output logic [7:0] rd);
    @(negedge sys_clk);
    cs_n_pin = 1'b0;
    repeat (8) @(negedge sys_clk);
    for (int i = 23; i >= 0; i--) begin
      sclk_pin = 1'b0;
      sdio_pin = frm[i];
      repeat (10) @(negedge sys_clk);
      if (i < 8) rd[i] = sdo;
      sclk_pin = 1'b1;
      repeat (10) @(negedge sys_clk);
    end
    sclk_pin = 1'b0;
    repeat (8) @(negedge sys_clk);
    cs_n_pin = 1'b1;
    // Released line shows the inverse so a stale value is never trusted.
    sdio_pin = ~sdio_pin;
    repeat (10) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ===== clock_input_path_and_system_ctrl_bench.sv
/* Self-checking bench for the clock input path block.
   Assumes the checker is bound in and the host model drives the port. */
`timescale 1ns/10ps
`default_nettype none
module clock_input_path_and_system_ctrl_bench;
  logic sys_clk, sys_rst, sclk_pin, cs_n_pin, sdio_pin, sync_n_pin, sdo, sdo_oe;
  logic prescale_static, prescale_bypass, src_internal, pd_input_section;
  logic pd_osc_interface, pd_sources, pd_sync, pd_dist_ref;
  logic [2:0] chan_ignore_sync, chan_direct, chan_hold, chan_sync_pulse, seen_pulse;
  logic clr_seen, seen_oe;
  logic [3:0] prescale_ratio;
  logic [7:0] r;
  clk_path_pkg::chan_src_t [2:0] chan_src;
  int miscompares;
  int checked;

  clock_input_path_and_system_ctrl #(.N_CHAN(3)) i_clock_input_path_and_system_ctrl (
    .sys_clk, .sys_rst, .sclk_pin, .cs_n_pin, .sdio_pin, .sync_n_pin, .chan_ignore_sync,
    .chan_direct, .sdo, .sdo_oe, .prescale_ratio, .prescale_static, .prescale_bypass,
    .src_internal, .pd_input_section, .pd_osc_interface, .pd_sources, .pd_sync,
    .pd_dist_ref, .chan_hold, .chan_sync_pulse, .chan_src);
  serial_host_model i_serial_host_model (.sys_clk, .sdo, .sclk_pin, .cs_n_pin, .sdio_pin);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Sticky records of one-cycle pulses and of the read driver, cleared by reset and by the tests.
  always @(posedge sys_clk) begin
    if (sys_rst || clr_seen) begin
      seen_pulse <= 3'h0;
      seen_oe    <= 1'b0;
    end else begin
      seen_pulse <= seen_pulse | chan_sync_pulse;
      seen_oe    <= seen_oe | sdo_oe;
    end
  end

  // ==========================================================
  // Tasks.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_serial_host_model.xfer({3'h0, a, d}, x);
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    i_serial_host_model.xfer({3'h4, a, 8'h00}, d);
  endtask
  task automatic clear_seen;
    clr_seen = 1'b1;
    @(negedge sys_clk);
    clr_seen = 1'b0;
  endtask
  // The read frame's first clock rise performs the armed copy.
  task automatic apply;
    logic [7:0] x;
    wr(clk_path_pkg::ADDR_APPLY, 8'h01);
    rd(clk_path_pkg::ADDR_APPLY, x);
    check("update bit", x, 8'h00);
  endtask
  task automatic close_out;
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests.
  initial begin
    sys_rst = 1'b1;
    sync_n_pin = 1'b1;
    chan_ignore_sync = 3'h2;
    chan_direct = 3'h5;
    clr_seen = 1'b0;
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("ratio", prescale_ratio, 8'h04);
    check("pd", {pd_input_section, pd_osc_interface, pd_sources, pd_sync, pd_dist_ref,
      src_internal, prescale_bypass, prescale_static}, 8'h00);
    check("hold", chan_hold, 8'h00);
    rd(clk_path_pkg::ADDR_PRESCALE, r);
    check("prescale reg", r, 8'h02);
    check("read driver", {seen_oe, sdo_oe}, 8'h02);
    rd(13'h0100, r);
    check("unmapped", r, 8'h00);
    wr(clk_path_pkg::ADDR_INPUT_PATH, 8'h1C);
    check("pd early", {pd_input_section, pd_osc_interface, pd_sources}, 8'h00);
    rd(clk_path_pkg::ADDR_INPUT_PATH, r);
    check("path reg", r, 8'h1C);
    wr(clk_path_pkg::ADDR_APPLY, 8'h01);
    check("pd armed", {pd_input_section, pd_osc_interface, pd_sources}, 8'h00);
    apply;
    check("pd", {pd_input_section, pd_osc_interface, pd_sources}, 8'h07);
    // static codes come last, standing in for after calibration.
    for (int c = 0; c < 8; c++) begin
      wr(clk_path_pkg::ADDR_PRESCALE, 8'(c));
      apply;
      check("ratio", prescale_ratio, (c < 5) ? 8'(c + 2) : 8'h00);
      check("static", prescale_static, 8'(c > 4));
    end
    // Code 3 breaks the host's pairing rule on purpose to see it refused.
    for (int m = 0; m < 4; m++) begin
      wr(clk_path_pkg::ADDR_INPUT_PATH, 8'(m));
      apply;
      check("source", src_internal, 8'(m[1]));
      check("bypass", prescale_bypass, 8'(m == 1));
      check("direct", chan_src[0], (m == 0) ? 8'(clk_path_pkg::SRC_EXT) :
        (m == 2) ? 8'(clk_path_pkg::SRC_OSC) : 8'(clk_path_pkg::SRC_DIVIDER));
      check("plain", chan_src[1], 8'(clk_path_pkg::SRC_DIVIDER));
    end
    wr(clk_path_pkg::ADDR_SYSTEM, 8'h07);
    apply;
    check("pd sys", {pd_sync, pd_dist_ref}, 8'h03);
    check("hold pd", chan_hold, 8'h00);
    wr(clk_path_pkg::ADDR_SYSTEM, 8'h01);
    apply;
    check("hold soft", chan_hold, 8'h05);
    clear_seen;
    wr(clk_path_pkg::ADDR_SYSTEM, 8'h00);
    apply;
    check("pulse soft", {chan_hold, seen_pulse}, 8'h05);
    sync_n_pin = 1'b0;
    repeat (12) @(negedge sys_clk);
    check("hold pin", chan_hold, 8'h05);
    clear_seen;
    sync_n_pin = 1'b1;
    repeat (12) @(negedge sys_clk);
    check("pulse pin", {chan_hold, seen_pulse}, 8'h05);
    close_out;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    close_out;
  end
endmodule
`default_nettype wire
